// ==== design/fci_pkg.sv ====
// Constants, opcodes and state types of the flash command host controller
package fci_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Field positions
  localparam int CTRL_ALT_BIT   = 4;
  localparam int CTRL_GO_BIT    = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_REFUSE_BIT = 1;
  localparam int STAT_DONE_BIT  = 2;
  localparam int STAT_MODE_LSB  = 4;

  // Operations software can order
  localparam logic [3:0] OP_READ_ARRAY  = 4'h0;
  localparam logic [3:0] OP_READ_STATUS = 4'h1;
  localparam logic [3:0] OP_READ_ID     = 4'h2;
  localparam logic [3:0] OP_PROGRAM     = 4'h3;
  localparam logic [3:0] OP_ERASE       = 4'h4;
  localparam logic [3:0] OP_SUSPEND     = 4'h5;
  localparam logic [3:0] OP_RESUME      = 4'h6;
  localparam logic [3:0] OP_CLEAR_STAT  = 4'h7;
  localparam logic [3:0] OP_RAW_CMD     = 4'h8;
  localparam logic [3:0] OP_RESET       = 4'h9;

  // Command bytes of the device
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROGRAM    = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] RSV_0 = 8'h00;
  localparam logic [7:0] RSV_1 = 8'h01;
  localparam logic [7:0] RSV_2 = 8'h60;
  localparam logic [7:0] RSV_3 = 8'h2F;
  localparam logic [7:0] RSV_4 = 8'hC0;
  localparam logic [7:0] RSV_5 = 8'h98;

  // Timing: figures in ns, counts derived from the 4 ns clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS     = 100;
  localparam int RECOV_NS      = 20;
  localparam int RST_LOW_NS    = 1000;
  localparam int RST_WAKE_NS   = 1000;
  localparam int CNT_W         = 16;
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RECOV_CYC =
    CNT_W'((RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RST_LOW_CYC =
    CNT_W'((RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RST_WAKE_CYC =
    CNT_W'((RST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Device read mode as tracked by the host
  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_STATUS = 2'b01,
    MODE_ID     = 2'b10
  } fci_mode_t;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b10,
    CY_RECOV  = 2'b11
  } fci_cyc_state_t;

  typedef enum logic [2:0] {
    SQ_IDLE    = 3'b000,
    SQ_RUN1    = 3'b001,
    SQ_RUN2    = 3'b010,
    SQ_RSTLOW  = 3'b011,
    SQ_RSTWAKE = 3'b100
  } fci_seq_state_t;

endpackage

// ==== design/fci_pin_cycle.sv ====
// One read or write bus cycle on the flash pins
`timescale 1ns/1ns
module fci_pin_cycle #(
  parameter int ADDR_W = 22
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              start,
  input  wire logic              isWrite,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [15:0]       dataIn,
  input  wire logic [15:0]       flashDqIn,
  output logic                   ceN,
  output logic                   oeN,
  output logic                   weN,
  output logic [ADDR_W-1:0]      addrOut,
  output logic [15:0]            dqOut,
  output logic                   dqOe,
  output logic [15:0]            readData,
  output logic                   done
);

  fci_pkg::fci_cyc_state_t state_q, state_d;
  logic [fci_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic ceN_q, ceN_d, oeN_q, oeN_d, weN_q, weN_d, dqOe_q, dqOe_d, wr_q, wr_d, done_q, done_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [15:0] dq_q, dq_d, rd_q, rd_d;

  // Cycle sequencing; address and data stay put from setup to recovery
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ceN_d   = ceN_q;
    oeN_d   = oeN_q;
    weN_d   = weN_q;
    dqOe_d  = dqOe_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    dq_d    = dq_q;
    rd_d    = rd_q;
    done_d  = 1'b0;
    unique case (state_q)
      fci_pkg::CY_IDLE: begin
        if (start) begin
          addr_d  = addrIn;
          dq_d    = dataIn;
          wr_d    = isWrite;
          ceN_d   = 1'b0;
          dqOe_d  = isWrite;
          state_d = fci_pkg::CY_SETUP;
        end
      end
      fci_pkg::CY_SETUP: begin
        // Output-enable stays high on writes, write-enable high on reads
        if (wr_q) begin
          weN_d = 1'b0;
        end else begin
          oeN_d = 1'b0;
        end
        cnt_d   = fci_pkg::STROBE_CYC - fci_pkg::CNT_W'(1);
        state_d = fci_pkg::CY_STROBE;
      end
      fci_pkg::CY_STROBE: begin
        if (cnt_q == '0) begin
          if (!wr_q) begin
            rd_d = flashDqIn;
          end
          // Active strobe and chip enable rise together; device latches on this edge
          weN_d   = 1'b1;
          oeN_d   = 1'b1;
          ceN_d   = 1'b1;
          cnt_d   = fci_pkg::RECOV_CYC - fci_pkg::CNT_W'(1);
          state_d = fci_pkg::CY_RECOV;
        end else begin
          cnt_d = cnt_q - fci_pkg::CNT_W'(1);
        end
      end
      fci_pkg::CY_RECOV: begin
        // Data held one cycle past the rising strobe for hold time
        dqOe_d = 1'b0;
        if (cnt_q == '0) begin
          done_d  = 1'b1;
          state_d = fci_pkg::CY_IDLE;
        end else begin
          cnt_d = cnt_q - fci_pkg::CNT_W'(1);
        end
      end
    endcase
  end

  // Registers; pins idle high and undriven at reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= fci_pkg::CY_IDLE;
      cnt_q   <= '0;
      ceN_q   <= 1'b1;
      oeN_q   <= 1'b1;
      weN_q   <= 1'b1;
      dqOe_q  <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      dq_q    <= 16'h0000;
      rd_q    <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ceN_q   <= ceN_d;
      oeN_q   <= oeN_d;
      weN_q   <= weN_d;
      dqOe_q  <= dqOe_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      dq_q    <= dq_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
    end
  end

  assign ceN      = ceN_q;
  assign oeN      = oeN_q;
  assign weN      = weN_q;
  assign addrOut  = addr_q;
  assign dqOut    = dq_q;
  assign dqOe     = dqOe_q;
  assign readData = rd_q;
  assign done     = done_q;

endmodule

// ==== design/fci_host.sv ====
// APB-controlled host that sequences commands to a parallel boot flash
`timescale 1ns/1ns
module fci_host #(
  parameter int ADDR_W = 22
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN,
  output logic                   flashRpN,
  output logic [ADDR_W-1:0]      flashAddr,
  output logic [15:0]            flashDqOut,
  output logic                   flashDqOe,
  input  wire logic [15:0]       flashDqIn
);

  // Reserved codes are refused before they reach the pins
  function automatic logic isReserved(input logic [7:0] c);
    isReserved = (c == fci_pkg::RSV_0) || (c == fci_pkg::RSV_1) || (c == fci_pkg::RSV_2) ||
                 (c == fci_pkg::RSV_3) || (c == fci_pkg::RSV_4) || (c == fci_pkg::RSV_5);
  endfunction

  logic        cycDone;
  logic [15:0] cycRead;

  // APB and register state
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [3:0]  op_q, op_d;
  logic        alt_q, alt_d, refuse_q, refuse_d, done_q, done_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;

  // Sequencer state and planned cycles
  fci_pkg::fci_seq_state_t sq_q, sq_d;
  fci_pkg::fci_mode_t mode_q, mode_d, nextMode_q, nextMode_d;
  logic [fci_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic        start_q, start_d, rpN_q, rpN_d;
  logic        p2Valid_q, p2Valid_d, p1Wr_q, p1Wr_d, p2Wr_q, p2Wr_d, step2_q, step2_d;
  logic [ADDR_W-1:0] p1Addr_q, p1Addr_d, p2Addr_q, p2Addr_d;
  logic [15:0] p1Data_q, p1Data_d, p2Data_q, p2Data_d;

  logic        busy, wrAcc, goReq;

  assign busy  = (sq_q != fci_pkg::SQ_IDLE);
  assign wrAcc = psel && penable && pready_q && pwrite;
  assign goReq = wrAcc && (paddr == fci_pkg::OFS_CTRL) && pwdata[fci_pkg::CTRL_GO_BIT];

  fci_pin_cycle #(.ADDR_W(ADDR_W)) fci_pin_cycle_i (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .start     (start_q),
    .isWrite   (step2_q ? p2Wr_q : p1Wr_q),
    .addrIn    (step2_q ? p2Addr_q : p1Addr_q),
    .dataIn    (step2_q ? p2Data_q : p1Data_q),
    .flashDqIn (flashDqIn),
    .ceN       (flashCeN),
    .oeN       (flashOeN),
    .weN       (flashWeN),
    .addrOut   (flashAddr),
    .dqOut     (flashDqOut),
    .dqOe      (flashDqOe),
    .readData  (cycRead),
    .done      (cycDone)
  );

  // APB slave: zero wait, answer in the first access cycle
  always_comb begin
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    op_d      = op_q;
    alt_d     = alt_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    if (psel && !penable) begin
      unique case (paddr)
        fci_pkg::OFS_CTRL:   prdata_d = {27'h0, alt_q, op_q};
        fci_pkg::OFS_ADDR:   prdata_d = 32'(addr_q);
        fci_pkg::OFS_WDATA:  prdata_d = {16'h0000, wdata_q};
        fci_pkg::OFS_RDATA:  prdata_d = {16'h0000, rdata_q};
        fci_pkg::OFS_STATUS: prdata_d = {26'h0, mode_q, 1'b0, done_q, refuse_q, busy};
        default:             pslverr_d = 1'b1;
      endcase
    end
    // Configuration is frozen while an operation runs
    if (wrAcc && !busy) begin
      unique case (paddr)
        fci_pkg::OFS_CTRL: begin
          op_d  = pwdata[3:0];
          alt_d = pwdata[fci_pkg::CTRL_ALT_BIT];
        end
        fci_pkg::OFS_ADDR:  addr_d  = pwdata[ADDR_W-1:0];
        fci_pkg::OFS_WDATA: wdata_d = pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Operation planner and sequencer
  always_comb begin
    logic [7:0] raw;
    raw        = wdata_q[7:0];
    sq_d       = sq_q;
    mode_d     = mode_q;
    nextMode_d = nextMode_q;
    cnt_d      = cnt_q;
    start_d    = 1'b0;
    rpN_d      = rpN_q;
    step2_d    = step2_q;
    p2Valid_d  = p2Valid_q;
    p1Wr_d     = p1Wr_q;
    p2Wr_d     = p2Wr_q;
    p1Addr_d   = p1Addr_q;
    p2Addr_d   = p2Addr_q;
    p1Data_d   = p1Data_q;
    p2Data_d   = p2Data_q;
    rdata_d    = rdata_q;
    refuse_d   = refuse_q;
    done_d     = done_q;
    // Sticky flags clear on writing one; a new event below wins
    if (wrAcc && paddr == fci_pkg::OFS_STATUS) begin
      if (pwdata[fci_pkg::STAT_REFUSE_BIT]) refuse_d = 1'b0;
      if (pwdata[fci_pkg::STAT_DONE_BIT]) done_d = 1'b0;
    end
    unique case (sq_q)
      fci_pkg::SQ_IDLE: begin
        if (goReq) begin
          step2_d    = 1'b0;
          p1Wr_d     = 1'b1;
          p2Wr_d     = 1'b0;
          p1Addr_d   = addr_q;
          p2Addr_d   = addr_q;
          p2Valid_d  = 1'b0;
          nextMode_d = mode_q;
          start_d    = 1'b1;
          sq_d       = fci_pkg::SQ_RUN1;
          unique case (pwdata[3:0])
            fci_pkg::OP_READ_ARRAY: begin
              if (mode_q == fci_pkg::MODE_ARRAY) begin
                p1Wr_d = 1'b0;
              end else begin
                p1Data_d  = {8'h00, fci_pkg::CMD_READ_ARRAY};
                p2Valid_d = 1'b1;
              end
              nextMode_d = fci_pkg::MODE_ARRAY;
            end
            fci_pkg::OP_READ_STATUS: begin
              p1Data_d   = {8'h00, fci_pkg::CMD_READ_STAT};
              p2Valid_d  = 1'b1;
              nextMode_d = fci_pkg::MODE_STATUS;
            end
            fci_pkg::OP_READ_ID: begin
              p1Data_d   = {8'h00, fci_pkg::CMD_READ_ID};
              p2Addr_d   = {{(ADDR_W-1){1'b0}}, addr_q[0]};
              p2Valid_d  = 1'b1;
              nextMode_d = fci_pkg::MODE_ID;
            end
            fci_pkg::OP_PROGRAM: begin
              p1Data_d   = {8'h00, pwdata[fci_pkg::CTRL_ALT_BIT] ?
                            fci_pkg::CMD_PROGRAM_ALT : fci_pkg::CMD_PROGRAM};
              p2Wr_d     = 1'b1;
              p2Data_d   = wdata_q;
              p2Valid_d  = 1'b1;
              nextMode_d = fci_pkg::MODE_STATUS;
            end
            fci_pkg::OP_ERASE: begin
              p1Data_d   = {8'h00, fci_pkg::CMD_ERASE_SETUP};
              p2Wr_d     = 1'b1;
              p2Data_d   = {8'h00, fci_pkg::CMD_CONFIRM};
              p2Valid_d  = 1'b1;
              nextMode_d = fci_pkg::MODE_STATUS;
            end
            fci_pkg::OP_SUSPEND: begin
              p1Data_d   = {8'h00, fci_pkg::CMD_SUSPEND};
              nextMode_d = fci_pkg::MODE_STATUS;
            end
            fci_pkg::OP_RESUME: begin
              p1Data_d   = {8'h00, fci_pkg::CMD_CONFIRM};
              nextMode_d = fci_pkg::MODE_STATUS;
            end
            fci_pkg::OP_CLEAR_STAT: begin
              p1Data_d = {8'h00, fci_pkg::CMD_CLEAR_STAT};
            end
            fci_pkg::OP_RAW_CMD: begin
              p1Data_d = {8'h00, raw};
              if (isReserved(raw)) begin
                start_d  = 1'b0;
                sq_d     = fci_pkg::SQ_IDLE;
                refuse_d = 1'b1;
              end else if (raw == fci_pkg::CMD_READ_ARRAY) begin
                nextMode_d = fci_pkg::MODE_ARRAY;
              end else if (raw == fci_pkg::CMD_READ_ID) begin
                nextMode_d = fci_pkg::MODE_ID;
              end else if (raw != fci_pkg::CMD_CLEAR_STAT) begin
                // Any other code may start work; treat reads as status from now
                nextMode_d = fci_pkg::MODE_STATUS;
              end
            end
            fci_pkg::OP_RESET: begin
              start_d = 1'b0;
              rpN_d   = 1'b0;
              cnt_d   = fci_pkg::RST_LOW_CYC - fci_pkg::CNT_W'(1);
              sq_d    = fci_pkg::SQ_RSTLOW;
            end
            default: begin
              start_d  = 1'b0;
              sq_d     = fci_pkg::SQ_IDLE;
              refuse_d = 1'b1;
            end
          endcase
        end
      end
      fci_pkg::SQ_RUN1, fci_pkg::SQ_RUN2: begin
        if (goReq) begin
          refuse_d = 1'b1;
        end
        if (cycDone) begin
          if (sq_q == fci_pkg::SQ_RUN1 && p2Valid_q) begin
            step2_d = 1'b1;
            start_d = 1'b1;
            sq_d    = fci_pkg::SQ_RUN2;
          end else begin
            if (!(step2_q ? p2Wr_q : p1Wr_q)) begin
              rdata_d = cycRead;
            end
            mode_d = nextMode_q;
            done_d = 1'b1;
            sq_d   = fci_pkg::SQ_IDLE;
          end
        end
      end
      fci_pkg::SQ_RSTLOW: begin
        if (goReq) refuse_d = 1'b1;
        if (cnt_q == '0) begin
          rpN_d = 1'b1;
          cnt_d = fci_pkg::RST_WAKE_CYC - fci_pkg::CNT_W'(1);
          sq_d  = fci_pkg::SQ_RSTWAKE;
        end else begin
          cnt_d = cnt_q - fci_pkg::CNT_W'(1);
        end
      end
      fci_pkg::SQ_RSTWAKE: begin
        if (goReq) refuse_d = 1'b1;
        if (cnt_q == '0) begin
          mode_d = fci_pkg::MODE_ARRAY;
          done_d = 1'b1;
          sq_d   = fci_pkg::SQ_IDLE;
        end else begin
          cnt_d = cnt_q - fci_pkg::CNT_W'(1);
        end
      end
      default: sq_d = fci_pkg::SQ_IDLE;
    endcase
  end

  // Reset runs a power-down pulse so the device starts from a known mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      op_q       <= 4'h0;
      alt_q      <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= 16'h0000;
      rdata_q    <= 16'h0000;
      refuse_q   <= 1'b0;
      done_q     <= 1'b0;
      sq_q       <= fci_pkg::SQ_RSTLOW;
      mode_q     <= fci_pkg::MODE_ARRAY;
      nextMode_q <= fci_pkg::MODE_ARRAY;
      cnt_q      <= fci_pkg::RST_LOW_CYC - fci_pkg::CNT_W'(1);
      start_q    <= 1'b0;
      rpN_q      <= 1'b0;
      step2_q    <= 1'b0;
      p2Valid_q  <= 1'b0;
      p1Wr_q     <= 1'b0;
      p2Wr_q     <= 1'b0;
      p1Addr_q   <= '0;
      p2Addr_q   <= '0;
      p1Data_q   <= 16'h0000;
      p2Data_q   <= 16'h0000;
    end else begin
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      op_q       <= op_d;
      alt_q      <= alt_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      rdata_q    <= rdata_d;
      refuse_q   <= refuse_d;
      done_q     <= done_d;
      sq_q       <= sq_d;
      mode_q     <= mode_d;
      nextMode_q <= nextMode_d;
      cnt_q      <= cnt_d;
      start_q    <= start_d;
      rpN_q      <= rpN_d;
      step2_q    <= step2_d;
      p2Valid_q  <= p2Valid_d;
      p1Wr_q     <= p1Wr_d;
      p2Wr_q     <= p2Wr_d;
      p1Addr_q   <= p1Addr_d;
      p2Addr_q   <= p2Addr_d;
      p1Data_q   <= p1Data_d;
      p2Data_q   <= p2Data_d;
    end
  end

  assign pready   = pready_q;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign flashRpN = rpN_q;

endmodule

// ==== tb/fci_host_asserts.sv ====
// Protocol and pin-timing checker bound to the flash host controller
`timescale 1ns/1ns
module fci_host_asserts (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN,
  input wire logic        flashRpN,
  input wire logic        flashDqOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Zero-wait slave: one answer cycle per setup
  a_pready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  a_unmapped_error: assert property (psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (psel && !penable && paddr <= 8'h10 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access flagged as error");
  // Pin combinations of read and write cycles
  a_read_pins: assert property (!flashOeN |-> flashWeN && !flashCeN && flashRpN && !flashDqOe)
    else $error("bad pin levels during read");
  a_write_pins: assert property (!flashWeN |-> !flashCeN && flashOeN && flashDqOe && flashRpN)
    else $error("bad pin levels during write");
  // Strobe widths follow the chosen 25-cycle strobe
  a_write_width: assert property ($fell(flashWeN) |-> ##24 !flashWeN ##1 flashWeN)
    else $error("write strobe width wrong");
  a_read_width: assert property ($fell(flashOeN) |-> ##24 !flashOeN ##1 flashOeN)
    else $error("read strobe width wrong");
  a_rp_quiet: assert property (!flashRpN |-> flashCeN && flashOeN && flashWeN && !flashDqOe)
    else $error("strobes active during power-down");
  a_dq_release: assert property ($rose(flashWeN) |-> ##[1:2] !flashDqOe)
    else $error("data bus not released after write");
  a_rst_powerdown: assert property ($fell(sys_rst) |-> !flashRpN && flashCeN)
    else $error("device not held in reset after release");
endmodule
bind fci_host fci_host_asserts fci_host_asserts_i (.core_clk, .sys_rst, .psel, .penable,
  .paddr, .pready, .prdata, .pslverr, .flashCeN, .flashOeN, .flashWeN, .flashRpN, .flashDqOe);

// ==== tb/fci_flash_model.sv ====
// Behavioural model of the flash command decoder and status register
`timescale 1ns/1ns
module fci_flash_model #(
  parameter logic [15:0] MAKER = 16'h00A5, // Arbitrary identity value
  parameter logic [15:0] PART  = 16'h5A3C  // Arbitrary identity value
) (
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        rpN,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dqIn,
  output logic [15:0]      dqOut
);
  logic [15:0] mem [16];
  logic [7:0]  sr;
  logic [1:0]  mode;
  logic [15:0] rd;
  logic [15:0] outQ = 16'h0000;
  logic        progArm, eraseArm, erasing, halted, wSel;
  initial foreach (mem[k]) mem[k] = 16'hFFFF;
  // Read source follows the mode
  always_comb begin
    case (mode)
      2'h1:    rd = {8'h00, sr};
      2'h2:    rd = addr[0] ? PART : MAKER;
      default: rd = mem[addr[3:0]];
    endcase
  end
  // Latched at falling output enable; released pins show the inverse, not stale data
  always @(negedge oeN) outQ = rd;
  assign dqOut = (!ceN && !oeN && rpN) ? outQ : ~outQ;
  // Select is taken at the falling strobe, since it may rise with the write strobe
  always @(negedge weN) wSel = !ceN && oeN;
  // Commands latch on the rising write strobe
  always @(posedge weN or negedge rpN) begin
    if (!rpN) begin
      mode = 2'h0;
      sr = 8'h80;
      {progArm, eraseArm, erasing, halted} = 4'h0;
    end else if (wSel) begin
      if (progArm) begin
        mem[addr[3:0]] = mem[addr[3:0]] & dqIn;
        progArm = 1'b0;
        mode = 2'h1;
      end else if (eraseArm) begin
        eraseArm = 1'b0;
        mode = 2'h1;
        if (dqIn[7:0] == 8'hD0) begin
          erasing = 1'b1;
          sr[7] = 1'b0;
        end else sr[5:4] = 2'h3;
      end else if (erasing && !halted) begin
        if (dqIn[7:0] == 8'h70) mode = 2'h1;
        if (dqIn[7:0] == 8'hB0) begin
          halted = 1'b1;
          sr[7:6] = 2'h3;
        end
      end else if (halted && dqIn[7:0] == 8'hD0) begin
        halted = 1'b0;
        sr[7:6] = 2'h0;
        mode = 2'h1;
      end else begin
        case (dqIn[7:0])
          8'hFF:        mode = 2'h0;
          8'h40, 8'h10: progArm = 1'b1;
          8'h20:        eraseArm = 1'b1;
          8'h70:        mode = 2'h1;
          8'h50:        sr = sr & 8'hC5;
          8'h90:        mode = 2'h2;
          default:      ;
        endcase
      end
    end
  end
endmodule

// ==== tb/test_flash_command_interface.sv ====
// Self-checking bench for the flash command host controller
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_flash_command_interface;
  localparam logic [15:0] MAKER = 16'h00A5; // Arbitrary identity value
  localparam logic [15:0] PART  = 16'h5A3C; // Arbitrary identity value
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, lfsr, aSave;
  logic        ceN, oeN, weN, rpN, dqOe;
  logic [21:0] fAddr;
  logic [15:0] dqOut, dqIn, modelDq;
  logic [15:0] pData [2];
  logic [32:0] expQ [$], mskQ [$];
  int          bad_count = 0, samples_checked = 0;
  // Host drives the shared data bus only while enabled
  assign dqIn = dqOe ? dqOut : modelDq;
  fci_host fci_host_i (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN),
    .flashRpN(rpN), .flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn));
  fci_flash_model #(.MAKER(MAKER), .PART(PART)) fci_flash_model_i (.ceN, .oeN, .weN, .rpN,
    .addr(fAddr), .dqIn(dqOut), .dqOut(modelDq));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nextRand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // One APB transfer; reads leave a note for the watcher
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] m = 33'h0, input logic [32:0] e = 33'h0);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      mskQ.push_back(m);
      expQ.push_back(e);
    end
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Poll until idle with done set, then clear done; done avoids a stale idle read
  task automatic waitDone();
    do apb(1'b0, fci_pkg::OFS_STATUS, 32'h0);
    while (rdat[fci_pkg::STAT_BUSY_BIT] !== 1'b0 || rdat[fci_pkg::STAT_DONE_BIT] !== 1'b1);
    apb(1'b1, fci_pkg::OFS_STATUS, 32'h0000_0004);
  endtask
  task automatic runOp(input logic [3:0] op, input logic alt = 1'b0);
    apb(1'b1, fci_pkg::OFS_CTRL, {23'h0, 1'b1, 3'h0, alt, op});
    waitDone();
  endtask
  task automatic raw(input logic [7:0] c);
    apb(1'b1, fci_pkg::OFS_WDATA, {24'h0, c});
    runOp(fci_pkg::OP_RAW_CMD);
  endtask
  task automatic readBack(input logic [15:0] e);
    apb(1'b0, fci_pkg::OFS_RDATA, 32'h0, {1'b1, 32'h0000_FFFF}, {17'h0, e});
  endtask
  // Watcher: each read answer with a nonzero mask is compared with the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      if (mskQ[0] != 33'h0) `CHK({pslverr, prdata} & mskQ[0], expQ[0])
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the expected run of a few thousand cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    lfsr = 32'h2681;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    waitDone();
    apb(1'b0, fci_pkg::OFS_STATUS, 32'h0, 33'h30, 33'h0);
    runOp(fci_pkg::OP_READ_STATUS);
    readBack(16'h0080);
    apb(1'b0, 8'h40, 32'h0, {33{1'b1}}, {1'b1, 32'h0});
    $display("Test reset and status done");
    for (int i = 0; i < 2; i++) begin
      pData[i] = 16'(nextRand());
      apb(1'b1, fci_pkg::OFS_ADDR, (nextRand() & 32'h003F_FFF0) | i);
      if (i == 0) aSave = pwdata;
      apb(1'b1, fci_pkg::OFS_WDATA, {16'h0, pData[i]});
      runOp(fci_pkg::OP_PROGRAM, i[0]);
      apb(1'b0, fci_pkg::OFS_STATUS, 32'h0, 33'h30, 33'h10);
      runOp(fci_pkg::OP_READ_ARRAY);
      readBack(pData[i]);
    end
    $display("Test program done");
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, fci_pkg::OFS_WDATA, {24'h0, k == 0 ? fci_pkg::RSV_0 : k == 1 ? fci_pkg::RSV_1 :
        k == 2 ? fci_pkg::RSV_2 : k == 3 ? fci_pkg::RSV_3 : k == 4 ? fci_pkg::RSV_4 : fci_pkg::RSV_5});
      apb(1'b1, fci_pkg::OFS_CTRL, k < 6 ? 32'h0000_0108 : 32'h0000_010A);
      apb(1'b0, fci_pkg::OFS_STATUS, 32'h0, 33'h2, 33'h2);
      apb(1'b1, fci_pkg::OFS_STATUS, 32'h0000_0006);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, fci_pkg::OFS_ADDR, (nextRand() & 32'h003F_FFFE) | i);
      runOp(fci_pkg::OP_READ_ID);
      readBack(i ? PART : MAKER);
    end
    $display("Test reserved and identifier done");
    raw(fci_pkg::CMD_ERASE_SETUP);
    raw(fci_pkg::CMD_READ_STAT);
    runOp(fci_pkg::OP_READ_STATUS);
    readBack(16'h00B0);
    runOp(fci_pkg::OP_CLEAR_STAT);
    raw(8'hA5);
    runOp(fci_pkg::OP_READ_STATUS);
    readBack(16'h0080);
    $display("Test erase error done");
    runOp(fci_pkg::OP_ERASE);
    runOp(fci_pkg::OP_READ_ARRAY);
    readBack(16'h0000);
    runOp(fci_pkg::OP_SUSPEND);
    runOp(fci_pkg::OP_READ_STATUS);
    readBack(16'h00C0);
    runOp(fci_pkg::OP_RESUME);
    runOp(fci_pkg::OP_READ_STATUS);
    readBack(16'h0000);
    runOp(fci_pkg::OP_RESET);
    apb(1'b1, fci_pkg::OFS_ADDR, aSave);
    runOp(fci_pkg::OP_READ_ARRAY);
    readBack(pData[0]);
    $display("Test erase suspend and reset done");
    report_and_stop();
  end
endmodule
